// File: pkg/usart_baud_pkg.sv
/*
  Constants, field layouts and carrier types of the bit-rate generator and
  the receiver/transmitter enable control. Assumes a 32-bit APB register bus.
*/
package usart_baud_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_HOLDING = 8'h1c;
  localparam logic [7:0] OFS_BAUD = 8'h20;
  localparam logic [7:0] OFS_RATIO = 8'h40;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CR_RX_RESET = 2;
  localparam int CR_TX_RESET = 3;
  localparam int CR_RX_ENABLE = 4;
  localparam int CR_RX_DISABLE = 5;
  localparam int CR_TX_ENABLE = 6;
  localparam int CR_TX_DISABLE = 7;
  localparam int MR_PORT_LSB = 0;
  localparam int MR_SRC_LSB = 4;
  localparam int MR_SYNC_BIT = 8;
  localparam int MR_CARD_CLK_BIT = 18;
  localparam int MR_OVER_BIT = 19;
  localparam int BAUD_DIVISOR_LSB = 0;
  localparam int BAUD_FRACTION_LSB = 16;
  localparam int ST_HOLD_FREE = 1;
  localparam int ST_DONE = 9;
  localparam int ST_RX_ON = 16;
  localparam int ST_TX_ON = 17;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [3:0] PORT_NORMAL = 4'h0;
  localparam logic [3:0] PORT_CARD_T0 = 4'h4;
  localparam logic [3:0] PORT_CARD_T1 = 4'h6;
  localparam logic [1:0] SRC_MASTER = 2'h0;
  localparam logic [1:0] SRC_MASTER_DIV = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [2:0] FRACTION_RESET = 3'h0;
  localparam logic [10:0] RATIO_RESET = 11'h174;
  localparam int PRESCALE_DEFAULT = 8;
  localparam logic [16:0] OVERSAMPLE_8 = 17'h00008;
  localparam logic [16:0] OVERSAMPLE_16 = 17'h00010;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] port_mode;
    logic [1:0] src;
    logic sync;
    logic card_clock_output_enable;
    logic over;
  } mode_t;

  localparam mode_t MODE_RESET = '{port_mode: 4'h0, src: 2'h0, sync: 1'b0,
                                   card_clock_output_enable: 1'b0, over: 1'b0};

  typedef struct packed {
    logic sample;
    logic bitclk;
    logic sck;
    logic sck_en;
  } rate_out_t;

  typedef enum logic [2:0] {
    DIR_OFF = 3'b001,
    DIR_ON = 3'b010,
    DIR_DRAIN = 3'b100
  } dir_state_t;

endpackage

// File: logic/level_sync.sv
/*
  Two-flop synchroniser for one level from outside the pclk domain.
  Assumes the level is slow against pclk.
*/
`timescale 1ns/1ns
module level_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

// File: logic/rate_divider.sv
/*
  Integer divider of a tick stream with optional one-eighth fractional step.
  Assumes src_tick is a one-cycle pulse in the pclk domain.
*/
`timescale 1ns/1ns
module rate_divider #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic [W-1:0] divisor,
  input wire logic [2:0] frac,
  input wire logic frac_en,
  output logic tick,
  output logic level
);

  logic [W-1:0] cnt;
  logic [2:0] acc;
  logic carry;
  logic [W-1:0] next_cnt;
  logic [2:0] next_acc;
  logic next_carry;
  logic next_tick;
  logic next_level;
  logic [W:0] period;
  logic [W:0] half;
  logic [3:0] acc_sum;

  generate
    if (W < 2) begin : g_bad_width
      $error("rate_divider width too small");
    end
  endgenerate

  always_comb begin
    // A carry lengthens one period by a source tick: mean divisor is whole plus fraction/8
    period = {1'b0, divisor} + {{W{1'b0}}, carry};
    half = (period + {{W{1'b0}}, 1'b1}) >> 1;
    acc_sum = {1'b0, acc} + {1'b0, frac};
    next_cnt = cnt;
    next_acc = acc;
    next_carry = carry;
    next_tick = 1'b0;
    next_level = level;
    if (divisor == '0) begin
      next_cnt = '0;
      next_acc = 3'h0;
      next_carry = 1'b0;
      next_level = 1'b0;
    end else if (src_tick) begin
      if ({1'b0, cnt} >= period - {{W{1'b0}}, 1'b1}) begin
        next_cnt = '0;
        next_tick = 1'b1;
        if (frac_en) begin
          next_acc = acc_sum[2:0];
          next_carry = acc_sum[3];
        end else begin
          next_acc = 3'h0;
          next_carry = 1'b0;
        end
      end else begin
        next_cnt = cnt + {{(W-1){1'b0}}, 1'b1};
      end
      if (period == {{W{1'b0}}, 1'b1}) begin
        // Divisor one: counter is idle, every source tick passes through
        next_level = ~level;
      end else begin
        next_level = ({1'b0, next_cnt} < half);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      acc <= 3'h0;
      carry <= 1'b0;
      tick <= 1'b0;
      level <= 1'b0;
    end else begin
      cnt <= next_cnt;
      acc <= next_acc;
      carry <= next_carry;
      tick <= next_tick;
      level <= next_level;
    end
  end

endmodule

// File: logic/usart_baud_ctrl.sv
/*
  Bit-rate generator and receiver/transmitter enable control of a serial
  port, with an APB register slave. Assumes the character engines sit
  outside and report busy levels in the pclk domain; the serial clock pin
  arrives asynchronously and is resolved by a pad from in/out/enable.
*/
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
module usart_baud_ctrl #(
  parameter int PRESCALE = usart_baud_pkg::PRESCALE_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic rx_char_busy,
  input wire logic tx_char_busy,
  output logic sample_tick,
  output logic bit_tick,
  output logic rx_enabled,
  output logic tx_enabled,
  output logic rx_reset,
  output logic tx_reset,
  output logic tx_start,
  output logic [8:0] tx_data
);

  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  generate
    if (PRESCALE < 2 || PRESCALE > 256) begin : g_bad_prescale
      $error("PRESCALE must lie in 2..256");
    end
  endgenerate

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == usart_baud_pkg::OFS_CONTROL) || (a == usart_baud_pkg::OFS_MODE) ||
             (a == usart_baud_pkg::OFS_STATUS) || (a == usart_baud_pkg::OFS_HOLDING) ||
             (a == usart_baud_pkg::OFS_BAUD) || (a == usart_baud_pkg::OFS_RATIO);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  usart_baud_pkg::mode_t mode;
  usart_baud_pkg::mode_t next_mode;
  logic [15:0] clock_divisor;
  logic [15:0] next_clock_divisor;
  logic [2:0] fraction_part;
  logic [2:0] next_fraction_part;
  logic [10:0] ratio;
  logic [10:0] next_ratio;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  usart_baud_pkg::dir_state_t rx_state;
  usart_baud_pkg::dir_state_t next_rx_state;
  usart_baud_pkg::dir_state_t tx_state;
  usart_baud_pkg::dir_state_t next_tx_state;
  logic hold_full;
  logic next_hold_full;
  logic [8:0] next_tx_data;
  logic next_tx_start;
  logic next_rx_reset;
  logic next_tx_reset;
  logic next_rx_enabled;
  logic next_tx_enabled;
  logic [PW-1:0] pre_cnt;
  logic [PW-1:0] next_pre_cnt;
  logic sck_s;
  logic sck_d;
  usart_baud_pkg::rate_out_t rate;
  usart_baud_pkg::rate_out_t next_rate;

  logic wr;
  logic [31:0] cmd;
  logic hold_free;
  logic tx_done;
  logic pre_tick;
  logic ext_tick;
  logic src_tick;
  logic card_mode;
  logic ext_direct;
  logic frac_en;
  logic [16:0] div2_divisor;
  logic t1;
  logic lvl1;
  logic t2;

  // ****************************************************************
  // APB slave: one access cycle, no wait states
  // ****************************************************************
  always_comb begin
    wr = psel & penable & pready & pwrite;
    cmd = (wr && paddr == usart_baud_pkg::OFS_CONTROL) ? pwdata : 32'h0000_0000;
    hold_free = (tx_state != usart_baud_pkg::DIR_OFF) & ~hold_full;
    tx_done = hold_free & ~tx_char_busy & ~tx_start;
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped(paddr);
    next_prdata = prdata;
    if (psel && !penable && (!pwrite || !mapped(paddr))) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        usart_baud_pkg::OFS_MODE: begin
          next_prdata[usart_baud_pkg::MR_PORT_LSB +: 4] = mode.port_mode;
          next_prdata[usart_baud_pkg::MR_SRC_LSB +: 2] = mode.src;
          next_prdata[usart_baud_pkg::MR_SYNC_BIT] = mode.sync;
          next_prdata[usart_baud_pkg::MR_CARD_CLK_BIT] = mode.card_clock_output_enable;
          next_prdata[usart_baud_pkg::MR_OVER_BIT] = mode.over;
        end
        usart_baud_pkg::OFS_STATUS: begin
          next_prdata[usart_baud_pkg::ST_HOLD_FREE] = hold_free;
          next_prdata[usart_baud_pkg::ST_DONE] = tx_done;
          next_prdata[usart_baud_pkg::ST_RX_ON] = rx_enabled;
          next_prdata[usart_baud_pkg::ST_TX_ON] = tx_enabled;
        end
        usart_baud_pkg::OFS_BAUD: begin
          next_prdata[usart_baud_pkg::BAUD_DIVISOR_LSB +: 16] = clock_divisor;
          next_prdata[usart_baud_pkg::BAUD_FRACTION_LSB +: 3] = fraction_part;
        end
        usart_baud_pkg::OFS_RATIO: begin
          next_prdata[10:0] = ratio;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
    // Configuration survives direction resets: only presetn clears it
    next_mode = mode;
    next_clock_divisor = clock_divisor;
    next_fraction_part = fraction_part;
    next_ratio = ratio;
    if (wr && paddr == usart_baud_pkg::OFS_MODE) begin
      next_mode.port_mode = pwdata[usart_baud_pkg::MR_PORT_LSB +: 4];
      next_mode.src = pwdata[usart_baud_pkg::MR_SRC_LSB +: 2];
      next_mode.sync = pwdata[usart_baud_pkg::MR_SYNC_BIT];
      next_mode.card_clock_output_enable = pwdata[usart_baud_pkg::MR_CARD_CLK_BIT];
      next_mode.over = pwdata[usart_baud_pkg::MR_OVER_BIT];
    end
    if (wr && paddr == usart_baud_pkg::OFS_BAUD) begin
      next_clock_divisor = pwdata[usart_baud_pkg::BAUD_DIVISOR_LSB +: 16];
      next_fraction_part = pwdata[usart_baud_pkg::BAUD_FRACTION_LSB +: 3];
    end
    if (wr && paddr == usart_baud_pkg::OFS_RATIO) begin
      next_ratio = pwdata[10:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode <= usart_baud_pkg::MODE_RESET;
      clock_divisor <= usart_baud_pkg::DIVISOR_RESET;
      fraction_part <= usart_baud_pkg::FRACTION_RESET;
      ratio <= usart_baud_pkg::RATIO_RESET;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      mode <= next_mode;
      clock_divisor <= next_clock_divisor;
      fraction_part <= next_fraction_part;
      ratio <= next_ratio;
    end
  end

  // ****************************************************************
  // Receiver and transmitter enable control
  // ****************************************************************
  always_comb begin
    next_rx_state = rx_state;
    next_tx_state = tx_state;
    next_hold_full = hold_full;
    next_tx_data = tx_data;
    next_rx_reset = cmd[usart_baud_pkg::CR_RX_RESET];
    next_tx_reset = cmd[usart_baud_pkg::CR_TX_RESET];
    case (rx_state)
      usart_baud_pkg::DIR_OFF: begin
        if (cmd[usart_baud_pkg::CR_RX_ENABLE] && !cmd[usart_baud_pkg::CR_RX_DISABLE]) begin
          next_rx_state = usart_baud_pkg::DIR_ON;
        end
      end
      usart_baud_pkg::DIR_ON: begin
        if (cmd[usart_baud_pkg::CR_RX_DISABLE]) begin
          next_rx_state = rx_char_busy ? usart_baud_pkg::DIR_DRAIN
                                       : usart_baud_pkg::DIR_OFF;
        end
      end
      usart_baud_pkg::DIR_DRAIN: begin
        if (cmd[usart_baud_pkg::CR_RX_ENABLE] && !cmd[usart_baud_pkg::CR_RX_DISABLE]) begin
          next_rx_state = usart_baud_pkg::DIR_ON;
        end else if (!rx_char_busy) begin
          next_rx_state = usart_baud_pkg::DIR_OFF;
        end
      end
      default: begin
        next_rx_state = usart_baud_pkg::DIR_OFF;
      end
    endcase
    if (cmd[usart_baud_pkg::CR_RX_RESET]) begin
      next_rx_state = usart_baud_pkg::DIR_OFF;
    end
    // Engine must raise tx_char_busy the cycle after tx_start
    next_tx_start = (tx_state != usart_baud_pkg::DIR_OFF) & hold_full & ~tx_char_busy &
                    ~tx_start;
    if (next_tx_start) begin
      next_hold_full = 1'b0;
    end
    if (wr && paddr == usart_baud_pkg::OFS_HOLDING && hold_free) begin
      next_hold_full = 1'b1;
      next_tx_data = pwdata[8:0];
    end
    case (tx_state)
      usart_baud_pkg::DIR_OFF: begin
        if (cmd[usart_baud_pkg::CR_TX_ENABLE] && !cmd[usart_baud_pkg::CR_TX_DISABLE]) begin
          next_tx_state = usart_baud_pkg::DIR_ON;
        end
      end
      usart_baud_pkg::DIR_ON: begin
        if (cmd[usart_baud_pkg::CR_TX_DISABLE]) begin
          next_tx_state = usart_baud_pkg::DIR_DRAIN;
        end
      end
      usart_baud_pkg::DIR_DRAIN: begin
        if (cmd[usart_baud_pkg::CR_TX_ENABLE] && !cmd[usart_baud_pkg::CR_TX_DISABLE]) begin
          next_tx_state = usart_baud_pkg::DIR_ON;
        end else if (!hold_full && !tx_char_busy && !tx_start) begin
          // Busy covers the timeguard, so it is kept before stopping
          next_tx_state = usart_baud_pkg::DIR_OFF;
        end
      end
      default: begin
        next_tx_state = usart_baud_pkg::DIR_OFF;
      end
    endcase
    if (cmd[usart_baud_pkg::CR_TX_RESET]) begin
      next_tx_state = usart_baud_pkg::DIR_OFF;
      next_hold_full = 1'b0;
      next_tx_start = 1'b0;
    end
    next_rx_enabled = (next_rx_state != usart_baud_pkg::DIR_OFF);
    next_tx_enabled = (next_tx_state != usart_baud_pkg::DIR_OFF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= usart_baud_pkg::DIR_OFF;
      tx_state <= usart_baud_pkg::DIR_OFF;
      hold_full <= 1'b0;
      tx_data <= 9'h000;
      tx_start <= 1'b0;
      rx_reset <= 1'b0;
      tx_reset <= 1'b0;
      rx_enabled <= 1'b0;
      tx_enabled <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      tx_state <= next_tx_state;
      hold_full <= next_hold_full;
      tx_data <= next_tx_data;
      tx_start <= next_tx_start;
      rx_reset <= next_rx_reset;
      tx_reset <= next_tx_reset;
      rx_enabled <= next_rx_enabled;
      tx_enabled <= next_tx_enabled;
    end
  end

  // ****************************************************************
  // Bit-rate generator
  // ****************************************************************
  // Pin edges are only seen reliably when sck is slow against pclk
  level_sync u_sck_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sck_in),
    .sync_out(sck_s)
  );

  always_comb begin
    pre_tick = (pre_cnt == PW'(PRESCALE - 1));
    next_pre_cnt = pre_tick ? '0 : pre_cnt + {{(PW-1){1'b0}}, 1'b1};
    ext_tick = sck_s & ~sck_d;
    case (mode.src)
      usart_baud_pkg::SRC_MASTER: src_tick = 1'b1;
      usart_baud_pkg::SRC_MASTER_DIV: src_tick = pre_tick;
      usart_baud_pkg::SRC_EXT: src_tick = ext_tick;
      default: src_tick = pre_tick;
    endcase
    card_mode = (mode.port_mode == usart_baud_pkg::PORT_CARD_T0) ||
                (mode.port_mode == usart_baud_pkg::PORT_CARD_T1);
    ext_direct = mode.sync & (mode.src == usart_baud_pkg::SRC_EXT);
    frac_en = (mode.port_mode == usart_baud_pkg::PORT_NORMAL) & ~mode.sync &
              (fraction_part != 3'h0);
    if (card_mode) begin
      div2_divisor = {6'h00, ratio};
    end else begin
      div2_divisor = mode.over ? usart_baud_pkg::OVERSAMPLE_8
                               : usart_baud_pkg::OVERSAMPLE_16;
    end
    next_rate.sample = ~mode.sync & ~card_mode & t1;
    if (ext_direct) begin
      next_rate.bitclk = ext_tick;
    end else if (mode.sync && !card_mode) begin
      next_rate.bitclk = t1;
    end else begin
      next_rate.bitclk = t2;
    end
    next_rate.sck_en = (mode.sync & ~ext_direct & ~card_mode) |
                       (card_mode & mode.card_clock_output_enable);
    // High phase is the first half of each period, rounded up for odd divisors
    next_rate.sck = lvl1 & next_rate.sck_en;
  end

  rate_divider #(
    .W(16)
  ) u_main_div (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .divisor(clock_divisor),
    .frac(fraction_part),
    .frac_en(frac_en),
    .tick(t1),
    .level(lvl1)
  );

  rate_divider #(
    .W(17)
  ) u_sample_div (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(t1),
    .divisor(div2_divisor),
    .frac(3'h0),
    .frac_en(1'b0),
    .tick(t2),
    .level()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= '0;
      sck_d <= 1'b0;
      rate <= '0;
    end else begin
      pre_cnt <= next_pre_cnt;
      sck_d <= sck_s;
      rate <= next_rate;
    end
  end

  always_comb begin
    sample_tick = rate.sample;
    bit_tick = rate.bitclk;
    sck_out = rate.sck;
    sck_oe = rate.sck_en;
  end

endmodule

// File: verification/usart_baud_properties.sv
/*
  Checker of bus answers and enable control of usart_baud_ctrl.
  Assumes it is bound into usart_baud_ctrl and sees its ports only.
*/
`timescale 1ns/1ns
module usart_baud_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_char_busy,
  input wire logic rx_enabled,
  input wire logic tx_enabled,
  input wire logic rx_reset,
  input wire logic tx_reset,
  input wire logic tx_start,
  input wire logic sck_out,
  input wire logic sck_oe
);
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic ctl = psel & penable & pwrite & pready & (paddr == usart_baud_pkg::OFS_CONTROL);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cmd(int b);
    ctl && pwdata[b];
  endsequence
  property p_answer;
    s_setup |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_unmapped;
    pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("refused read data not zero");
  property p_rx_on;
    s_cmd(4) ##0 (!pwdata[5] && !pwdata[2]) |=> rx_enabled;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receiver not enabled");
  property p_dis_wins;
    s_cmd(4) ##0 (pwdata[5] && !rx_enabled) |=> !rx_enabled;
  endproperty
  a_dis_wins: assert property (p_dis_wins) else $error("enable beat disable");
  // A busy receiver keeps running through a disable, only a reset stops it
  property p_drain;
    rx_enabled && rx_char_busy && !(ctl && pwdata[2]) |=> rx_enabled;
  endproperty
  a_drain: assert property (p_drain) else $error("receiver cut a character");
  property p_tx_rst;
    s_cmd(3) |=> tx_reset && !tx_enabled;
  endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("transmitter reset late");
  property p_rx_rst;
    s_cmd(2) |=> rx_reset && !rx_enabled;
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("receiver reset late");
  property p_start;
    tx_start |-> tx_enabled ##1 !tx_start;
  endproperty
  a_start: assert property (p_start) else $error("bad hand-over pulse");
  property p_pin;
    sck_out |-> sck_oe;
  endproperty
  a_pin: assert property (p_pin) else $error("pin level without enable");
endmodule

bind usart_baud_ctrl usart_baud_properties i_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .rx_char_busy(rx_char_busy),
  .rx_enabled(rx_enabled),
  .tx_enabled(tx_enabled),
  .rx_reset(rx_reset),
  .tx_reset(tx_reset),
  .tx_start(tx_start),
  .sck_out(sck_out),
  .sck_oe(sck_oe)
);

// File: verification/usart_far_model.sv
/*
  Far-side model: character engine busy levels and a remote pin clock.
  Assumes the bench pulses rx_go and holds ext_run while a pin clock is wanted.
*/
`timescale 1ns/1ns
module usart_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_start,
  input wire logic rx_go,
  input wire logic ext_run,
  output logic sck_in,
  output logic rx_char_busy,
  output logic tx_char_busy
);
  // ********************************
  // Busy timers and pin clock
  // ********************************
  int tx_cnt;
  int rx_cnt;
  int ph;
  assign tx_char_busy = tx_cnt > 0;
  assign rx_char_busy = rx_cnt > 0;
  // Pin clock stands still outside runs; a 10 cycle period stays below pclk/4.5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= 0;
      rx_cnt <= 0;
      ph <= 0;
      sck_in <= 1'b0;
    end else begin
      tx_cnt <= tx_start ? 40 : (tx_cnt > 0 ? tx_cnt - 1 : 0);
      rx_cnt <= rx_go ? 30 : (rx_cnt > 0 ? rx_cnt - 1 : 0);
      ph <= (ph == 4) ? 0 : ph + 1;
      if (ext_run && ph == 4) begin
        sck_in <= ~sck_in;
      end
    end
  end
endmodule

// File: verification/usart_baud_and_enable_control_tb_top.sv
/*
  Self-checking bench of usart_baud_ctrl with the far-side model.
  Assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ns
module usart_baud_and_enable_control_tb_top;
  // ********************************
  // Bench
  // ********************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic rx_go = 1'b0;
  logic ext_run = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [8:0] tx_data;
  logic pready, pslverr, sck_in, sck_out, sck_oe, rx_char_busy, tx_char_busy, er;
  logic sample_tick, bit_tick, rx_enabled, tx_enabled, rx_reset, tx_reset, tx_start;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  usart_baud_ctrl i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sck_in(sck_in),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .rx_char_busy(rx_char_busy),
    .tx_char_busy(tx_char_busy),
    .sample_tick(sample_tick),
    .bit_tick(bit_tick),
    .rx_enabled(rx_enabled),
    .tx_enabled(tx_enabled),
    .rx_reset(rx_reset),
    .tx_reset(tx_reset),
    .tx_start(tx_start),
    .tx_data(tx_data)
  );
  usart_far_model i_far (
    .pclk(pclk),
    .presetn(presetn),
    .tx_start(tx_start),
    .rx_go(rx_go),
    .ext_run(ext_run),
    .sck_in(sck_in),
    .rx_char_busy(rx_char_busy),
    .tx_char_busy(tx_char_busy)
  );
  always begin
    #5;
    pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tx_start !== 1'b1 && n < 100);
    check(tx_start, 1'b1);
  endtask
  function automatic logic [31:0] md(int p, int s, int y, int c, int o);
    return p | (s << 4) | (y << 8) | (c << 18) | (o << 19);
  endfunction
  // Counts ticks over 480 cycles; one tick of slack covers the window phase
  task automatic rate(input logic [31:0] m, input logic [31:0] b, input int es, input int eb,
                      input int ek = -1);
    int s;
    int t;
    int k;
    apb(1'b1, 8'h04, m);
    apb(1'b1, 8'h20, b);
    repeat (20) @(posedge pclk);
    s = 0;
    t = 0;
    k = 0;
    repeat (480) begin
      @(posedge pclk);
      s += (sample_tick === 1'b1);
      t += (bit_tick === 1'b1);
      k += (sck_out === 1'b1);
    end
    if (es >= 0) check(s >= es - 1 && s <= es + 1, 1'b1);
    if (ek >= 0) check(k >= ek - 2 && k <= ek + 2, 1'b1);
    check(t >= eb - 1 && t <= eb + 1, 1'b1);
  endtask
  task automatic reset_case();
    apb(1'b0, 8'h14, 32'h0);
    check(rd & 32'h30202, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h174);
    apb(1'b0, 8'h80, 32'h0);
    check(er, 1'b1);
  endtask
  task automatic rate_cases();
    apb(1'b1, 8'h40, 32'h4);
    rate(md(0, 0, 0, 0, 1), 32'h2, 240, 30);
    rate(md(0, 0, 0, 0, 0), 32'h3, 160, 10);
    rate(md(0, 0, 0, 0, 1), 32'h1, 480, 60);
    rate(md(0, 0, 0, 0, 1), 32'h0, 0, 0);
    rate(md(0, 1, 0, 0, 1), 32'h1, 60, 7);
    rate(md(0, 0, 0, 0, 1), 32'h40002, 192, 24);
    rate(md(4, 0, 0, 1, 1), 32'h40002, -1, 60, 240);
    check(sck_oe, 1'b1);
    rate(md(0, 0, 1, 0, 0), 32'h4, 0, 120, 240);
    ext_run <= 1'b1;
    rate(md(0, 3, 1, 0, 0), 32'h0, 0, 48, 0);
    ext_run <= 1'b0;
  endtask
  task automatic tx_case();
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b0, 8'h14, 32'h0);
    check(rd & 32'h20002, 32'h20002);
    apb(1'b1, 8'h1c, 32'h1a5);
    wait_start();
    check(tx_data, 9'h1a5);
    apb(1'b1, 8'h1c, 32'h05a);
    apb(1'b1, 8'h00, 32'h80);
    wait_start();
    check(tx_data, 9'h05a);
    check(tx_enabled, 1'b1);
    repeat (45) @(posedge pclk);
    check(tx_enabled, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    check(rd & 32'h202, 32'h0);
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b1, 8'h1c, 32'h0ff);
    wait_start();
    apb(1'b1, 8'h00, 32'h08);
    repeat (2) @(posedge pclk);
    check(tx_enabled, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h4);
  endtask
  task automatic rx_case();
    apb(1'b1, 8'h00, 32'h10);
    rx_go <= 1'b1;
    @(posedge pclk);
    rx_go <= 1'b0;
    apb(1'b1, 8'h00, 32'h20);
    repeat (3) @(posedge pclk);
    check(rx_enabled, 1'b1);
    repeat (40) @(posedge pclk);
    check(rx_enabled, 1'b0);
    apb(1'b1, 8'h00, 32'h30);
    repeat (2) @(posedge pclk);
    check(rx_enabled, 1'b0);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h00, 32'h04);
    @(posedge pclk);
    check(rx_enabled, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    reset_case();
    rate_cases();
    tx_case();
    rx_case();
    stop_test();
  end
endmodule
